// file: fpp_pkg.sv
/*
 * Constants for the fuse programming sequencer: array shape, tape
 * characters and timing figures with their cycle counts at 200 MHz.
 * Assumes the including design runs on a single 200 MHz clock.
 */
package fpp_pkg;
    // ****************************************************************
    // Array shape
    // ****************************************************************
    localparam int ADDR_W = 9;              // Word address width
    localparam int DATA_W = 8;              // Word data width
    localparam int WORDS = 512;             // Words in the array
    localparam logic [8:0] LAST_ADDR = 9'h1ff; // Highest word address
    localparam logic [2:0] LAST_BIT = 3'h7; // Highest bit index

    // ****************************************************************
    // Tape characters (seven-bit code, parity bit stripped)
    // ****************************************************************
    localparam logic [6:0] CH_START = 7'h42; // Word start letter
    localparam logic [6:0] CH_HIGH = 7'h50;  // Bit high letter
    localparam logic [6:0] CH_LOW = 7'h4e;   // Bit low letter
    localparam logic [6:0] CH_END = 7'h46;   // Word end letter
    localparam logic [6:0] CH_RUB = 7'h7f;   // Rubout
    localparam logic [5:0] MIN_RUBS = 6'h19; // Least leader/trailer run, only the trailer run is checked
    localparam logic [3:0] BITS_PER = 4'h8;  // Level letters per word

    // ****************************************************************
    // Timing, figures as printed, counts derived at 5 ns per cycle
    // ****************************************************************
    localparam int CLK_PS = 5000;
    localparam int FIRST_US = 75;      // First pulse, within 50..100 us
    localparam int NEXT_US = 5000;     // Further pulse, 5 ms
    localparam int TOTAL_MS = 400;     // Cumulative limit per link
    localparam int GAP_NS = 500;       // Edge gap, above 100 ns
    localparam int VERIFY_US = 2;      // Sense window, user chosen
    localparam int READ_NS = 100;      // Final read settle, above access
    localparam int BURST_MS = 5000;    // Continuous programming limit
    localparam int REST_MS = 5000;     // Power-off rest after burst
    localparam int FIRST_CYC = FIRST_US * 1000000 / CLK_PS;
    // Cycles per microsecond first, so the product stays inside int
    localparam int NEXT_CYC = NEXT_US * (1000000 / CLK_PS);
    localparam int GAP_CYC = (GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int VERIFY_CYC = VERIFY_US * 1000000 / CLK_PS;
    localparam int READ_CYC = READ_NS * 1000 / CLK_PS;
    localparam longint TOTAL_CYC = longint'(TOTAL_MS) * 1000000000 / CLK_PS;
    localparam longint BURST_CYC = longint'(BURST_MS) * 1000000000 / CLK_PS;
    localparam longint REST_CYC = longint'(REST_MS) * 1000000000 / CLK_PS;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_LOAD   = 4'h0,  // Parsing tape into the pattern memory
        ST_SCAN   = 4'h1,  // Looking for the next bit to open
        ST_SEL    = 4'h2,  // Select raised to logic high
        ST_SUPPLY = 4'h3,  // Output fusing level applied
        ST_PULSE  = 4'h4,  // Select at fusing level
        ST_DROP   = 4'h5,  // Select back to logic high
        ST_OFF    = 4'h6,  // Output supply removed
        ST_SENSE  = 4'h7,  // Chip enabled, output on load
        ST_REST   = 4'h8,  // Cooling with power removed
        ST_VERIFY = 4'h9,  // Final read of every word
        ST_DONE   = 4'ha,  // Finished good
        ST_FAIL   = 4'hb   // Halted on failure
    } fpp_state_t;

    typedef enum logic [1:0] {
        PS_IDLE = 2'h0,   // Between words
        PS_BITS = 2'h1,   // Collecting level letters
        PS_END  = 2'h2    // Awaiting the end letter
    } fpp_parse_t;
endpackage

// file: fpp_programmer.sv
/*
 * Fuse programming sequencer: parses a letter-coded tape stream into a
 * 512 x 8 pattern memory, opens links one at a time on the PROM and
 * verifies every word. Assumes a tape byte source with valid/ready,
 * external analog switches driven by the level-control outputs, and
 * PROM data lines returned asynchronously on prom_data.
 */
`timescale 1ns/1ps
module fpp_programmer #(
    parameter longint TOTAL_LIM = fpp_pkg::TOTAL_CYC,
    parameter longint BURST_LIM = fpp_pkg::BURST_CYC,
    parameter longint REST_LIM  = fpp_pkg::REST_CYC,
    parameter int     NEXT_LIM  = fpp_pkg::NEXT_CYC
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Tape stream
    input  wire logic       tape_valid,
    input  wire logic [7:0] tape_char,
    output logic            tape_ready,
    // PROM pins
    output logic [8:0]      prom_addr,
    output logic            sel1_n,
    output logic            sel1_fuse,
    output logic            sel2_n,
    output logic            sel3,
    output logic            sel4,
    output logic [7:0]      out_fuse_en,
    output logic            out_load_en,
    output logic            prom_power,
    input  wire logic [7:0] prom_data,
    // Status
    output logic            busy,
    output logic            done,
    output logic            fail,
    output logic [1:0]      fail_code
);
    // ****************************************************************
    // Storage and state
    // ****************************************************************
    logic [7:0]          pattern_mem [fpp_pkg::WORDS]; // Target words
    fpp_pkg::fpp_state_t state_r;       // Sequencer state
    fpp_pkg::fpp_parse_t pst_r;         // Parser state
    logic [8:0]          waddr_r;       // Next word slot from tape
    logic                tape_full_r;   // All words received
    logic [5:0]          rub_r;         // Trailing rubout run
    logic [7:0]          shf_r;         // Word under assembly
    logic [3:0]          nbits_r;       // Level letters seen
    logic [8:0]          addr_r;        // Programming/verify address
    logic [2:0]          bit_r;         // Bit being opened
    logic                first_r;       // First attempt on this link
    logic [31:0]         tmr_r;         // Phase timer
    logic [63:0]         link_r;        // Cumulative time on link
    logic [63:0]         burst_r;       // Continuous programming time
    logic [7:0]          d1_r;          // Data sync stage one
    logic [7:0]          d2_r;          // Data sync stage two
    logic                fail_r;        // Failure flag
    logic [1:0]          fcode_r;       // Failure cause
    logic                verr_r;        // Verify mismatch seen
    logic [6:0]          ch;            // Character, parity stripped
    logic                take;          // Character accepted

    // Phase-time check shared by every timed state except ST_REST
    function automatic logic elapsed(input logic [31:0] t, input int n);
        elapsed = (t >= 32'(n - 1));
    endfunction

    assign ch = tape_char[6:0];
    assign tape_ready = (state_r == fpp_pkg::ST_LOAD);
    assign take = tape_valid && tape_ready;

    // ****************************************************************
    // Input synchroniser for the returned PROM data
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            d1_r <= 8'h00;
            d2_r <= 8'h00;
        end else begin
            d1_r <= prom_data;
            d2_r <= d1_r;
        end
    end

    // ****************************************************************
    // Tape parser
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pst_r <= fpp_pkg::PS_IDLE;
            waddr_r <= 9'h000;
            tape_full_r <= 1'b0;
            rub_r <= 6'h00;
            shf_r <= 8'h00;
            nbits_r <= 4'h0;
        end else if (take) begin
            // Count rubout runs for the trailer check
            if (ch == fpp_pkg::CH_RUB) begin
                if (rub_r != fpp_pkg::MIN_RUBS) begin
                    rub_r <= rub_r + 6'h01;
                end
            end else begin
                rub_r <= 6'h00;
            end
            case (pst_r)
                fpp_pkg::PS_IDLE: begin
                    // Leader, gaps and comments are skipped
                    if (ch == fpp_pkg::CH_START && !tape_full_r) begin
                        pst_r <= fpp_pkg::PS_BITS;
                        nbits_r <= 4'h0;
                    end
                end
                fpp_pkg::PS_BITS: begin
                    if (ch == fpp_pkg::CH_HIGH || ch == fpp_pkg::CH_LOW) begin
                        // Most significant bit arrives first
                        shf_r <= {shf_r[6:0], ch == fpp_pkg::CH_HIGH};
                        nbits_r <= nbits_r + 4'h1;
                        if (nbits_r == fpp_pkg::BITS_PER - 4'h1) begin
                            pst_r <= fpp_pkg::PS_END;
                        end
                    end else if (ch == fpp_pkg::CH_RUB) begin
                        pst_r <= fpp_pkg::PS_IDLE;
                    end else begin
                        pst_r <= fpp_pkg::PS_IDLE;
                    end
                end
                fpp_pkg::PS_END: begin
                    pst_r <= fpp_pkg::PS_IDLE;
                    if (ch == fpp_pkg::CH_END) begin
                        pattern_mem[waddr_r] <= shf_r;
                        waddr_r <= waddr_r + 9'h001;
                        if (waddr_r == fpp_pkg::LAST_ADDR) begin
                            tape_full_r <= 1'b1;
                        end
                    end
                end
                default: pst_r <= fpp_pkg::PS_IDLE;
            endcase
        end
    end

    // Malformed character inside a word (rubouts cancel instead)
    logic fmt_err;
    always_comb begin
        fmt_err = 1'b0;
        if (take && pst_r == fpp_pkg::PS_BITS) begin
            fmt_err = ch != fpp_pkg::CH_HIGH && ch != fpp_pkg::CH_LOW
                      && ch != fpp_pkg::CH_RUB;
        end else if (take && pst_r == fpp_pkg::PS_END) begin
            fmt_err = ch != fpp_pkg::CH_END && ch != fpp_pkg::CH_RUB;
        end
    end

    // ****************************************************************
    // Fusing sequencer
    // ****************************************************************
    logic [7:0] want; // Target word at the current address
    assign want = pattern_mem[addr_r];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= fpp_pkg::ST_LOAD;
            addr_r <= 9'h000;
            bit_r <= 3'h0;
            first_r <= 1'b1;
            tmr_r <= 32'h0;
            link_r <= 64'h0;
            burst_r <= 64'h0;
            fail_r <= 1'b0;
            fcode_r <= 2'h0;
            verr_r <= 1'b0;
        end else begin
            tmr_r <= tmr_r + 32'h1;
            // Heating time runs while any fusing step is active
            if (state_r inside {fpp_pkg::ST_SEL, fpp_pkg::ST_SUPPLY,
                                fpp_pkg::ST_PULSE, fpp_pkg::ST_DROP,
                                fpp_pkg::ST_OFF, fpp_pkg::ST_SENSE}) begin
                burst_r <= burst_r + 64'h1;
            end
            if (state_r == fpp_pkg::ST_PULSE) begin
                link_r <= link_r + 64'h1;
            end
            case (state_r)
                fpp_pkg::ST_LOAD: begin
                    tmr_r <= 32'h0;
                    if (fmt_err) begin
                        fail_r <= 1'b1;
                        fcode_r <= 2'h1;
                        state_r <= fpp_pkg::ST_FAIL;
                    end else if (tape_full_r && rub_r == fpp_pkg::MIN_RUBS) begin
                        state_r <= fpp_pkg::ST_SCAN;
                    end
                end
                fpp_pkg::ST_SCAN: begin
                    tmr_r <= 32'h0;
                    first_r <= 1'b1;
                    link_r <= 64'h0;
                    // Only bits wanted high are fused
                    if (want[bit_r]) begin
                        state_r <= fpp_pkg::ST_SEL;
                    end else if (bit_r != fpp_pkg::LAST_BIT) begin
                        bit_r <= bit_r + 3'h1;
                    end else if (addr_r != fpp_pkg::LAST_ADDR) begin
                        bit_r <= 3'h0;
                        addr_r <= addr_r + 9'h001;
                    end else begin
                        addr_r <= 9'h000;
                        state_r <= fpp_pkg::ST_VERIFY;
                    end
                end
                fpp_pkg::ST_SEL: begin
                    if (elapsed(tmr_r, fpp_pkg::GAP_CYC)) begin
                        tmr_r <= 32'h0;
                        state_r <= fpp_pkg::ST_SUPPLY;
                    end
                end
                fpp_pkg::ST_SUPPLY: begin
                    if (elapsed(tmr_r, fpp_pkg::GAP_CYC)) begin
                        tmr_r <= 32'h0;
                        state_r <= fpp_pkg::ST_PULSE;
                    end
                end
                fpp_pkg::ST_PULSE: begin
                    if (first_r ? elapsed(tmr_r, fpp_pkg::FIRST_CYC)
                                : elapsed(tmr_r, NEXT_LIM)) begin
                        tmr_r <= 32'h0;
                        state_r <= fpp_pkg::ST_DROP;
                    end
                end
                fpp_pkg::ST_DROP: begin
                    if (elapsed(tmr_r, fpp_pkg::GAP_CYC)) begin
                        tmr_r <= 32'h0;
                        state_r <= fpp_pkg::ST_OFF;
                    end
                end
                fpp_pkg::ST_OFF: begin
                    if (elapsed(tmr_r, fpp_pkg::GAP_CYC)) begin
                        tmr_r <= 32'h0;
                        state_r <= fpp_pkg::ST_SENSE;
                    end
                end
                fpp_pkg::ST_SENSE: begin
                    if (elapsed(tmr_r, fpp_pkg::VERIFY_CYC)) begin
                        tmr_r <= 32'h0;
                        first_r <= 1'b0;
                        if (d2_r[bit_r]) begin
                            state_r <= fpp_pkg::ST_SCAN;
                            if (bit_r != fpp_pkg::LAST_BIT) begin
                                bit_r <= bit_r + 3'h1;
                            end else begin
                                bit_r <= 3'h0;
                                if (addr_r != fpp_pkg::LAST_ADDR) begin
                                    addr_r <= addr_r + 9'h001;
                                end else begin
                                    state_r <= fpp_pkg::ST_VERIFY;
                                    addr_r <= 9'h000;
                                end
                            end
                        end else if (link_r >= TOTAL_LIM) begin
                            fail_r <= 1'b1;
                            fcode_r <= 2'h2;
                            state_r <= fpp_pkg::ST_FAIL;
                        end else if (burst_r >= BURST_LIM) begin
                            state_r <= fpp_pkg::ST_REST;
                        end else begin
                            state_r <= fpp_pkg::ST_SEL;
                        end
                    end
                end
                fpp_pkg::ST_REST: begin
                    burst_r <= 64'h0;
                    if (64'(tmr_r) >= REST_LIM - 64'h1) begin
                        tmr_r <= 32'h0;
                        state_r <= fpp_pkg::ST_SEL;
                    end
                end
                fpp_pkg::ST_VERIFY: begin
                    // Short settle per word: pin lag, access, two syncs
                    if (elapsed(tmr_r, fpp_pkg::READ_CYC)) begin
                        tmr_r <= 32'h0;
                        if (d2_r != want) begin
                            verr_r <= 1'b1;
                        end
                        if (addr_r != fpp_pkg::LAST_ADDR) begin
                            addr_r <= addr_r + 9'h001;
                        end else if (verr_r || d2_r != want) begin
                            fail_r <= 1'b1;
                            fcode_r <= 2'h3;
                            state_r <= fpp_pkg::ST_FAIL;
                        end else begin
                            state_r <= fpp_pkg::ST_DONE;
                        end
                    end
                end
                default: tmr_r <= 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // Pin drive decoded from state
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prom_addr <= 9'h000;
            sel1_n <= 1'b1;
            sel1_fuse <= 1'b0;
            sel2_n <= 1'b1;
            sel3 <= 1'b0;
            sel4 <= 1'b0;
            out_fuse_en <= 8'h00;
            out_load_en <= 1'b0;
            prom_power <= 1'b0;
        end else begin
            prom_addr <= addr_r;
            prom_power <= !(state_r inside {fpp_pkg::ST_LOAD,
                            fpp_pkg::ST_REST, fpp_pkg::ST_FAIL});
            // Chip enabled only for sensing and final read
            if (state_r == fpp_pkg::ST_SENSE
                || state_r == fpp_pkg::ST_VERIFY) begin
                sel1_n <= 1'b0;
                sel2_n <= 1'b0;
                sel3 <= 1'b1;
                sel4 <= 1'b1;
            end else begin
                sel1_n <= 1'b1;
                sel2_n <= 1'b1;
                sel3 <= 1'b0;
                sel4 <= 1'b0;
            end
            sel1_fuse <= (state_r == fpp_pkg::ST_PULSE);
            out_fuse_en <= (state_r inside {fpp_pkg::ST_SUPPLY,
                            fpp_pkg::ST_PULSE, fpp_pkg::ST_DROP})
                           ? (8'h01 << bit_r) : 8'h00;
            out_load_en <= (state_r == fpp_pkg::ST_SENSE);
        end
    end

    assign busy = !(state_r inside {fpp_pkg::ST_DONE, fpp_pkg::ST_FAIL});
    assign done = (state_r == fpp_pkg::ST_DONE);
    assign fail = fail_r;
    assign fail_code = fcode_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_sel_before_supply: assert property (@(posedge sys_clk)
        disable iff (sys_rst) $rose(|out_fuse_en) |-> sel1_n)
        else $error("supply applied with select low");
    chk_fuse_needs_supply: assert property (@(posedge sys_clk)
        disable iff (sys_rst) sel1_fuse |-> |out_fuse_en)
        else $error("fuse level without output supply");
    chk_one_link_only: assert property (@(posedge sys_clk)
        disable iff (sys_rst) $onehot0(out_fuse_en))
        else $error("more than one output fused");
    chk_sense_no_supply: assert property (@(posedge sys_clk)
        disable iff (sys_rst) out_load_en |-> out_fuse_en == 8'h00)
        else $error("sensing with supply on");
    chk_gap_after_sel: assert property (@(posedge sys_clk)
        disable iff (sys_rst) $rose(|out_fuse_en) |-> !sel1_fuse [*2])
        else $error("edge gap too short");
    chk_read_enables: assert property (@(posedge sys_clk)
        disable iff (sys_rst) !sel1_n |-> !sel2_n && sel3 && sel4)
        else $error("bad read enable set");
    chk_rest_power_off: assert property (@(posedge sys_clk)
        disable iff (sys_rst) state_r == fpp_pkg::ST_REST ##1
        state_r == fpp_pkg::ST_REST |-> !prom_power)
        else $error("power on during rest");
    chk_fail_halts: assert property (@(posedge sys_clk)
        disable iff (sys_rst) fail |=> fail && !sel1_fuse)
        else $error("activity after failure");
    chk_fuse_only_high: assert property (@(posedge sys_clk)
        disable iff (sys_rst) state_r == fpp_pkg::ST_SEL |-> want[bit_r])
        else $error("fusing a bit wanted low");
    cov_pulse: cover property (@(posedge sys_clk) $fell(sel1_fuse));
    cov_retry: cover property (@(posedge sys_clk)
        state_r == fpp_pkg::ST_SENSE ##1 state_r == fpp_pkg::ST_SEL);
    cov_done: cover property (@(posedge sys_clk) $rose(done));
    cov_fail: cover property (@(posedge sys_clk) $rose(fail));
    cov_rest: cover property (@(posedge sys_clk)
        state_r == fpp_pkg::ST_SENSE ##1 state_r == fpp_pkg::ST_REST);
endmodule

// file: fpp_prom_model.sv
/* Behavioural 512 x 8 fusible PROM used as the sequencer's device.
   Assumes the sequencer's clock; reset stands for a fresh blank part. */
`timescale 1ns/1ps
module fpp_prom_model (
    // Clock and fresh-part reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Pulses a link needs to open, zero never opens
    input  wire logic [7:0] need,
    // Device pins
    input  wire logic [8:0] prom_addr,
    input  wire logic       sel1_n,
    input  wire logic       sel1_fuse,
    input  wire logic       sel2_n,
    input  wire logic       sel3,
    input  wire logic       sel4,
    input  wire logic [7:0] out_fuse_en,
    input  wire logic       prom_power,
    output logic      [7:0] prom_data
);
    logic [7:0] mem [512];        // Stored words
    int         cnt [4096];       // Pulses seen per link
    int         plen [$];         // Length of each fusing pulse
    int         run, gap, sup_gap; // Cycle counters
    logic       pf, pe, sel_ok;   // Last levels, select high at supply
    // ****************************************************************
    // Pulse timing and fusing
    // ****************************************************************
    always @(posedge sys_clk) begin
        pf <= sel1_fuse;
        pe <= |out_fuse_en;
        if (sys_rst) begin
            foreach (mem[i]) mem[i] = 8'h00;
            foreach (cnt[i]) cnt[i] = 0;
            plen.delete();
        end else begin
            gap = (|out_fuse_en && !pe) ? 0 : gap + 1;
            if (|out_fuse_en && !pe) sel_ok = sel1_n;
            if (sel1_fuse && !pf) sup_gap = gap;
            run = (sel1_fuse && !pf) ? 1 : run + int'(sel1_fuse);
            if (!sel1_fuse && pf) begin
                plen.push_back(run);
                for (int b = 0; b < 8; b++)
                    if (out_fuse_en[b] && prom_power) begin
                        cnt[prom_addr*8+b]++;
                        if (need != 0 && cnt[prom_addr*8+b] >= need)
                            mem[prom_addr][b] = 1'b1;
                    end
            end
        end
    end
    // Outputs valid only when enabled, otherwise inverse of the word
    assign prom_data = (prom_power && !sel1_n && !sel2_n && sel3 && sel4)
                     ? mem[prom_addr] : ~mem[prom_addr];
endmodule

// file: tb_top.sv
/* Self-checking bench for the fuse programming sequencer.
   Assumes the PROM model is compiled before this file. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("Error %s exp %0h seen %0h", n, e, g); end end
module tb_top;
    logic       sys_clk = 0, sys_rst = 1, tape_valid = 0, tape_ready;
    logic [7:0] tape_char = 0, need = 1, out_fuse_en, prom_data;
    logic [8:0] prom_addr;
    logic       sel1_n, sel1_fuse, sel2_n, sel3, sel4, out_load_en;
    logic       prom_power, busy, done, fail;
    logic [1:0] fail_code;
    int         n_mismatch = 0, cmp_count = 0, cyc = 0;
    // ****************************************************************
    // Design, device model, clock and timeout
    // ****************************************************************
    fpp_programmer #(.TOTAL_LIM(16000), .BURST_LIM(15000),
        .REST_LIM(50), .NEXT_LIM(200)) fpp_programmer_inst (.sys_clk,
        .sys_rst, .tape_valid, .tape_char, .tape_ready, .prom_addr,
        .sel1_n, .sel1_fuse, .sel2_n, .sel3, .sel4, .out_fuse_en,
        .out_load_en, .prom_power, .prom_data, .busy, .done, .fail,
        .fail_code);
    fpp_prom_model fpp_prom_model_inst (.sys_clk, .sys_rst, .need,
        .prom_addr, .sel1_n, .sel1_fuse, .sel2_n, .sel3, .sel4,
        .out_fuse_en, .prom_power, .prom_data);
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 100000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ****************************************************************
    // Tape and control tasks
    // ****************************************************************
    task print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task reset_dut(input logic [7:0] n);
        tape_valid <= 1'b0;
        sys_rst    <= 1'b1;
        need       <= n;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask
    // Offer one byte, held until an edge sees ready high
    task put(input logic [7:0] c);
        tape_valid <= 1'b1;
        tape_char  <= c;
        do @(negedge sys_clk); while (tape_ready !== 1'b1);
        @(posedge sys_clk);
    endtask
    task rubs(input int n);
        repeat (n) put(8'h7f);
    endtask
    task word(input logic [7:0] v);
        put(8'h42);
        for (int i = 7; i >= 0; i--) put(v[i] ? 8'h50 : 8'h4e);
        put(8'hc6);
        put(8'h0d);
    endtask
    // Full tape: first word v, then zeros, leader and trailer
    task tape(input logic [7:0] v);
        rubs(30);
        put(8'h37);
        word(v);
        put(8'h42);
        put(8'h50);
        rubs(2);
        for (int i = 1; i < 512; i++) word(8'h00);
        rubs(25);
        tape_valid <= 1'b0;
    endtask
    task wait_end();
        while (done !== 1'b1 && fail !== 1'b1) @(posedge sys_clk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_format();
        reset_dut(8'h01);
        rubs(25);
        put(8'h42);
        put(8'h50);
        put(8'h41);
        wait_end();
        `CHK("fail_code", 2'h1, fail_code)
        `CHK("tape_ready", 1'b0, tape_ready)
    endtask
    task t_stuck();
        reset_dut(8'h00);
        tape(8'h01);
        wait_end();
        `CHK("fail_code", 2'h2, fail_code)
        `CHK("first", fpp_pkg::FIRST_CYC, fpp_prom_model_inst.plen[0])
        `CHK("next", 200, fpp_prom_model_inst.plen[1])
    endtask
    task t_full();
        reset_dut(8'h02);
        tape(8'h81);
        wait_end();
        `CHK("done", 1'b1, done)
        `CHK("busy", 1'b0, busy)
        `CHK("word0", 8'h81, fpp_prom_model_inst.mem[0])
        `CHK("word1", 8'h00, fpp_prom_model_inst.mem[1])
        `CHK("pulses", 4, fpp_prom_model_inst.plen.size())
        `CHK("gap", 1'b1, fpp_prom_model_inst.sup_gap >= 100)
        `CHK("sel_first", 1'b1, fpp_prom_model_inst.sel_ok)
    endtask
    initial begin
        t_format();
        t_stuck();
        t_full();
        print_verdict();
    end
endmodule
